// File: hw/flash_cmd_cfg.svh
// Opcodes, geometry and timing constants of the flash command engine
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

`define OP_SEC_ERASE   8'h44
`define OP_SEC_PROG    8'h42
`define OP_RST_EN      8'h66
`define OP_RST         8'h99
`define OP_PAGE_PROG   8'h02
`define OP_QUAD_PROG   8'h32

`define CLK_MHZ        100
`define RESET_TIME_US  30
`define RESET_CYCLES   (`RESET_TIME_US * `CLK_MHZ)
`define SE_TIME_US     1000
`define SE_CYCLES      (`SE_TIME_US * `CLK_MHZ)
`define PP_TIME_US     100
`define PP_CYCLES      (`PP_TIME_US * `CLK_MHZ)

`define PIN_RESET      6'h20
`define PAGE_COUNT     9'h100
`define PROT_ALL_CODE  4'h8

`endif

// File: hw/flash_cmd_engine.sv
// Serial flash program, security-region and software reset command engine
//
// Overview of operation
// - Security erase accepted only when write_latch_flag was already set.
// - Security erase has opcode only; frame must end right after bit eight.
// - Valid erase starts sector_erase_time cycle with busy flag; latch cleared.
// - With otp_lock_bit set every security erase is ignored.
// - Three 256-byte regions at 00_10_xx..00_30_xx, byte index in low byte.
// - Security program is opcode, 3 address bytes, 1 to 256 data bytes.
// - Valid security program starts page_prog_time cycle, busy, latch cleared.
// - Security program ignored when the region's lock bit is set.
// - Reset needs enable opcode then reset opcode, each in own frame.
// - Any other command after enable cancels the armed reset.
// - Accepted reset aborts work and clears latch and volatile settings.
// - About 30 us of reinitialisation follow reset; commands are rejected.
// - Page program is opcode, 3 address bytes, data on SI, latch set.
// - Data beyond the page end wraps to the page's first byte.
// - Last 256 bytes win; unsent bytes of the page stay untouched.
// - Program frame must end exactly after a whole data byte.
// - Valid page program runs page_prog_time cycle, busy, latch cleared.
// - Program aimed at a protected page is not executed.
// - Quad program needs quad_io_allow; data moves on all four lines.
// - All host bits are sampled on the serial clock rising edge.
`timescale 1ns/1ns
`include "flash_cmd_cfg.svh"

module flash_cmd_engine #(
    parameter int unsigned PP_CYCLES = `PP_CYCLES,
    parameter int unsigned SE_CYCLES = `SE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        cs_n_pin,
    input  wire logic        sclk_pin,
    input  wire logic [3:0]  io_pin,
    input  wire logic        write_enable_set,
    input  wire logic        otp_lock_bit,
    input  wire logic [2:0]  per_region_lock_bits,
    input  wire logic        quad_io_allow,
    input  wire logic [4:0]  region_protect_field,
    output logic             write_latch_flag,
    output logic             op_in_progress_flag,
    output logic             device_busy,
    output logic             mem_wr_en,
    output logic             mem_wr_secure,
    output logic [23:0]      mem_wr_addr,
    output logic [7:0]       mem_wr_data,
    output logic             sec_erase_pulse,
    output logic             soft_reset_pulse
);

    logic [5:0]  pin_meta_reg;
    logic [5:0]  pin_sync_reg;
    logic        cs_n_prev_reg;
    logic        sclk_prev_reg;
    logic        frame_start;
    logic        frame_end;
    logic        sclk_rise;
    logic [3:0]  io_s;

    flash_cmd_pkg::frame_state_t  fstate_reg;
    flash_cmd_pkg::engine_state_t eng_reg;
    flash_cmd_pkg::cmd_kind_t     cmd_reg;
    flash_cmd_pkg::cmd_kind_t     kind_dec;

    logic [2:0]  bit_cnt_reg;
    logic [2:0]  bit_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [1:0]  addr_cnt_reg;
    logic [23:0] addr_reg;
    logic [7:0]  buf_ptr_reg;
    logic        extra_reg;
    logic        have_data_reg;
    logic        quad_data;
    logic        byte_done;
    logic        opc_done;
    logic        busy;

    logic [7:0]  page_buf [256];
    logic [255:0] valid_reg;

    logic        armed_reg;
    logic        wel_reg;
    logic [31:0] timer_reg;
    logic [8:0]  scan_reg;
    logic        prog_secure_reg;

    logic        sec_ok;
    logic        prot_hit;
    logic        go_serase;
    logic        go_prog;
    logic        go_rsten;
    logic        go_reset;

    logic        wr_en_reg;
    logic        wr_secure_reg;
    logic [23:0] wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        erase_pulse_reg;
    logic        reset_pulse_reg;

    // Block-protect decode: code n of 1 to 8 protects 2^(n-1) 64K blocks, codes above 8 protect all, bit 4 picks bottom
    function automatic logic page_prot(input logic [4:0] f, input logic [7:0] blk);
        logic [8:0] n;
        n = 9'h000;
        if (f[3:0] > `PROT_ALL_CODE) begin
            n = `PAGE_COUNT;
        end else if (f[3:0] != 4'h0) begin
            n = 9'h001 << (f[3:0] - 4'h1);
        end
        if (f[4]) begin
            page_prot = {1'b0, blk} < n;
        end else begin
            page_prot = (n != 9'h000) && ({1'b0, blk} >= (`PAGE_COUNT - n));
        end
    endfunction

    // Pin synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta_reg  <= `PIN_RESET;
            pin_sync_reg  <= `PIN_RESET;
            cs_n_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg  <= {cs_n_pin, sclk_pin, io_pin};
            pin_sync_reg  <= pin_meta_reg;
            cs_n_prev_reg <= pin_sync_reg[5];
            sclk_prev_reg <= pin_sync_reg[4];
        end
    end

    assign io_s        = pin_sync_reg[3:0];
    assign frame_start = cs_n_prev_reg & ~pin_sync_reg[5];
    assign frame_end   = ~cs_n_prev_reg & pin_sync_reg[5];
    assign sclk_rise   = pin_sync_reg[4] & ~sclk_prev_reg & ~pin_sync_reg[5];

    assign busy      = eng_reg != flash_cmd_pkg::E_IDLE;
    assign quad_data = (fstate_reg == flash_cmd_pkg::F_DATA) &&
                       (cmd_reg == flash_cmd_pkg::K_QPROG);
    // Quad data shifts a nibble per edge
    assign shift_next = quad_data ? {shift_reg[3:0], io_s} : {shift_reg[6:0], io_s[0]};
    assign bit_next   = bit_cnt_reg + (quad_data ? 3'h4 : 3'h1);
    assign byte_done  = sclk_rise && (bit_next == 3'h0);
    assign opc_done   = byte_done && (fstate_reg == flash_cmd_pkg::F_OPC);

    // Opcode decode; write commands need the latch and an idle engine
    always_comb begin
        kind_dec = flash_cmd_pkg::K_NONE;
        if (eng_reg != flash_cmd_pkg::E_RESET) begin
            unique case (shift_next)
                `OP_SEC_ERASE: if (!busy && wel_reg) kind_dec = flash_cmd_pkg::K_SERASE;
                `OP_SEC_PROG:  if (!busy && wel_reg) kind_dec = flash_cmd_pkg::K_SPROG;
                `OP_PAGE_PROG: if (!busy && wel_reg) kind_dec = flash_cmd_pkg::K_PPROG;
                `OP_QUAD_PROG: begin
                    if (!busy && wel_reg && quad_io_allow) begin
                        kind_dec = flash_cmd_pkg::K_QPROG;
                    end
                end
                `OP_RST_EN:    kind_dec = flash_cmd_pkg::K_RSTEN;
                `OP_RST:       kind_dec = flash_cmd_pkg::K_RST;
                default:       kind_dec = flash_cmd_pkg::K_NONE;
            endcase
        end
    end

    // Frame sequencer: opcode, address, data, or trailing bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fstate_reg    <= flash_cmd_pkg::F_IDLE;
            cmd_reg       <= flash_cmd_pkg::K_NONE;
            bit_cnt_reg   <= 3'h0;
            shift_reg     <= 8'h00;
            addr_cnt_reg  <= 2'h0;
            addr_reg      <= 24'h000000;
            buf_ptr_reg   <= 8'h00;
            extra_reg     <= 1'b0;
            have_data_reg <= 1'b0;
        end else if (frame_start) begin
            fstate_reg    <= flash_cmd_pkg::F_OPC;
            cmd_reg       <= flash_cmd_pkg::K_NONE;
            bit_cnt_reg   <= 3'h0;
            addr_cnt_reg  <= 2'h0;
            extra_reg     <= 1'b0;
            have_data_reg <= 1'b0;
        end else if (frame_end) begin
            fstate_reg <= flash_cmd_pkg::F_IDLE;
        end else if (sclk_rise && fstate_reg != flash_cmd_pkg::F_IDLE) begin
            bit_cnt_reg <= bit_next;
            shift_reg   <= shift_next;
            unique case (fstate_reg)
                flash_cmd_pkg::F_OPC: begin
                    if (byte_done) begin
                        cmd_reg <= kind_dec;
                        if (kind_dec == flash_cmd_pkg::K_SPROG ||
                            kind_dec == flash_cmd_pkg::K_PPROG ||
                            kind_dec == flash_cmd_pkg::K_QPROG) begin
                            fstate_reg <= flash_cmd_pkg::F_ADDR;
                        end else begin
                            fstate_reg <= flash_cmd_pkg::F_SKIP;
                        end
                    end
                end
                flash_cmd_pkg::F_ADDR: begin
                    if (byte_done) begin
                        addr_reg     <= {addr_reg[15:0], shift_next};
                        addr_cnt_reg <= addr_cnt_reg + 2'h1;
                        if (addr_cnt_reg == 2'h2) begin
                            fstate_reg  <= flash_cmd_pkg::F_DATA;
                            buf_ptr_reg <= shift_next;
                        end
                    end
                end
                flash_cmd_pkg::F_DATA: begin
                    if (byte_done) begin
                        buf_ptr_reg   <= buf_ptr_reg + 8'h01;
                        have_data_reg <= 1'b1;
                    end
                end
                flash_cmd_pkg::F_SKIP: extra_reg <= 1'b1;
                default: extra_reg <= 1'b1;
            endcase
        end
    end

    // Page buffer; later bytes overwrite earlier ones at the same index
    always_ff @(posedge clock) begin
        if (byte_done && fstate_reg == flash_cmd_pkg::F_DATA) begin
            page_buf[buf_ptr_reg] <= shift_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            valid_reg <= '0;
        end else if (byte_done && fstate_reg == flash_cmd_pkg::F_ADDR &&
                     addr_cnt_reg == 2'h2) begin
            valid_reg <= '0;
        end else if (byte_done && fstate_reg == flash_cmd_pkg::F_DATA) begin
            valid_reg[buf_ptr_reg] <= 1'b1;
        end
    end

    // End-of-frame checks
    assign sec_ok = (addr_reg[23:16] == 8'h00) && (addr_reg[15:14] == 2'h0) &&
                    (addr_reg[13:12] != 2'h0) && (addr_reg[11:8] == 4'h0) &&
                    !per_region_lock_bits[addr_reg[13:12] - 2'h1];
    assign prot_hit = page_prot(region_protect_field, addr_reg[23:16]);

    assign go_serase = frame_end && fstate_reg == flash_cmd_pkg::F_SKIP && !extra_reg &&
                       cmd_reg == flash_cmd_pkg::K_SERASE && wel_reg && !busy &&
                       !otp_lock_bit;
    assign go_prog = frame_end && fstate_reg == flash_cmd_pkg::F_DATA &&
                     bit_cnt_reg == 3'h0 && have_data_reg && wel_reg && !busy &&
                     (cmd_reg == flash_cmd_pkg::K_SPROG ? sec_ok : !prot_hit) &&
                     (cmd_reg != flash_cmd_pkg::K_QPROG || quad_io_allow);
    assign go_rsten = frame_end && fstate_reg == flash_cmd_pkg::F_SKIP && !extra_reg &&
                      cmd_reg == flash_cmd_pkg::K_RSTEN;
    assign go_reset = frame_end && fstate_reg == flash_cmd_pkg::F_SKIP && !extra_reg &&
                      cmd_reg == flash_cmd_pkg::K_RST && armed_reg;

    // Reset arming
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else if (go_rsten) begin
            armed_reg <= 1'b1;
        end else if (go_reset) begin
            armed_reg <= 1'b0;
        end else if (opc_done && shift_next != `OP_RST && shift_next != `OP_RST_EN) begin
            armed_reg <= 1'b0;
        end
    end

    // Write enable latch; a set in the same cycle as a clear wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wel_reg <= 1'b0;
        end else if (write_enable_set) begin
            wel_reg <= 1'b1;
        end else if (go_serase || go_prog || go_reset) begin
            wel_reg <= 1'b0;
        end
    end

    // Self-timed engine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eng_reg         <= flash_cmd_pkg::E_IDLE;
            timer_reg       <= 32'h0;
            scan_reg        <= 9'h000;
            prog_secure_reg <= 1'b0;
        end else if (go_reset) begin
            eng_reg   <= flash_cmd_pkg::E_RESET;
            timer_reg <= 32'(`RESET_CYCLES - 1);
        end else begin
            unique case (eng_reg)
                flash_cmd_pkg::E_IDLE: begin
                    if (go_serase) begin
                        eng_reg   <= flash_cmd_pkg::E_ERASE;
                        timer_reg <= SE_CYCLES - 32'h1;
                    end else if (go_prog) begin
                        eng_reg         <= flash_cmd_pkg::E_PROG;
                        timer_reg       <= PP_CYCLES - 32'h1;
                        scan_reg        <= 9'h000;
                        prog_secure_reg <= cmd_reg == flash_cmd_pkg::K_SPROG;
                    end
                end
                flash_cmd_pkg::E_PROG: begin
                    if (!scan_reg[8]) begin
                        scan_reg <= scan_reg + 9'h001;
                    end
                    if (timer_reg != 32'h0) begin
                        timer_reg <= timer_reg - 32'h1;
                    end else if (scan_reg[8]) begin
                        eng_reg <= flash_cmd_pkg::E_IDLE;
                    end
                end
                flash_cmd_pkg::E_ERASE, flash_cmd_pkg::E_RESET: begin
                    if (timer_reg != 32'h0) begin
                        timer_reg <= timer_reg - 32'h1;
                    end else begin
                        eng_reg <= flash_cmd_pkg::E_IDLE;
                    end
                end
            endcase
        end
    end

    // Array write port: only bytes that were sent are written
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_en_reg       <= 1'b0;
            wr_secure_reg   <= 1'b0;
            wr_addr_reg     <= 24'h000000;
            wr_data_reg     <= 8'h00;
            erase_pulse_reg <= 1'b0;
            reset_pulse_reg <= 1'b0;
        end else begin
            wr_en_reg <= eng_reg == flash_cmd_pkg::E_PROG && !scan_reg[8] &&
                         valid_reg[scan_reg[7:0]] && !go_reset;
            wr_secure_reg   <= prog_secure_reg;
            wr_addr_reg     <= {addr_reg[23:8], scan_reg[7:0]};
            wr_data_reg     <= page_buf[scan_reg[7:0]];
            erase_pulse_reg <= eng_reg == flash_cmd_pkg::E_ERASE && timer_reg == 32'h0 &&
                               !go_reset;
            reset_pulse_reg <= go_reset;
        end
    end

    assign write_latch_flag    = wel_reg;
    assign op_in_progress_flag = eng_reg == flash_cmd_pkg::E_ERASE ||
                                 eng_reg == flash_cmd_pkg::E_PROG;
    assign device_busy         = busy;
    assign mem_wr_en           = wr_en_reg;
    assign mem_wr_secure       = wr_secure_reg;
    assign mem_wr_addr         = wr_addr_reg;
    assign mem_wr_data         = wr_data_reg;
    assign sec_erase_pulse     = erase_pulse_reg;
    assign soft_reset_pulse    = reset_pulse_reg;

    a_erase_needs_wel: assert property (@(posedge clock) disable iff (rst)
        eng_reg == flash_cmd_pkg::E_ERASE && $past(eng_reg) == flash_cmd_pkg::E_IDLE
        |-> $past(wel_reg))
        else $error("erase started without write latch");

    a_erase_exact_frame: assert property (@(posedge clock) disable iff (rst)
        go_serase |-> $past(fstate_reg) == flash_cmd_pkg::F_SKIP && !extra_reg)
        else $error("erase accepted with extra bits");

    a_erase_lock: assert property (@(posedge clock) disable iff (rst)
        otp_lock_bit && eng_reg == flash_cmd_pkg::E_IDLE |=> eng_reg != flash_cmd_pkg::E_ERASE)
        else $error("erase started while regions locked");

    a_wip_clears_wel: assert property (@(posedge clock) disable iff (rst)
        $rose(op_in_progress_flag) && !$past(write_enable_set) |-> !write_latch_flag)
        else $error("write latch still set after cycle start");

    a_reset_armed: assert property (@(posedge clock) disable iff (rst)
        soft_reset_pulse |-> $past(armed_reg) && eng_reg == flash_cmd_pkg::E_RESET)
        else $error("reset without prior enable");

    a_reset_hold: assert property (@(posedge clock) disable iff (rst)
        soft_reset_pulse |-> (eng_reg == flash_cmd_pkg::E_RESET)[*8])
        else $error("reset interval ended early");

    a_reset_reject: assert property (@(posedge clock) disable iff (rst)
        eng_reg == flash_cmd_pkg::E_RESET |=> eng_reg inside {flash_cmd_pkg::E_RESET,
                                                             flash_cmd_pkg::E_IDLE})
        else $error("command accepted during reset");

    a_wr_in_page: assert property (@(posedge clock) disable iff (rst)
        mem_wr_en |-> mem_wr_addr[23:8] == addr_reg[23:8] && $past(op_in_progress_flag))
        else $error("write left the addressed page");

    a_sec_region: assert property (@(posedge clock) disable iff (rst)
        mem_wr_en && mem_wr_secure |-> mem_wr_addr[23:16] == 8'h00 &&
        mem_wr_addr[15:12] inside {4'h1, 4'h2, 4'h3} && mem_wr_addr[11:8] == 4'h0)
        else $error("security write outside regions");

    a_busy_ignores: assert property (@(posedge clock) disable iff (rst)
        eng_reg == flash_cmd_pkg::E_PROG |=> eng_reg != flash_cmd_pkg::E_ERASE)
        else $error("erase started during program");

endmodule

// File: hw/flash_cmd_pkg.sv
// Types shared by the flash command engine
package flash_cmd_pkg;

    typedef enum logic [2:0] {
        F_IDLE = 3'b000,
        F_OPC  = 3'b001,
        F_ADDR = 3'b010,
        F_DATA = 3'b011,
        F_SKIP = 3'b100
    } frame_state_t;

    typedef enum logic [1:0] {
        E_IDLE  = 2'b00,
        E_ERASE = 2'b01,
        E_PROG  = 2'b10,
        E_RESET = 2'b11
    } engine_state_t;

    typedef enum logic [2:0] {
        K_NONE   = 3'b000,
        K_SERASE = 3'b001,
        K_SPROG  = 3'b010,
        K_PPROG  = 3'b011,
        K_QPROG  = 3'b100,
        K_RSTEN  = 3'b101,
        K_RST    = 3'b110
    } cmd_kind_t;

endpackage

// File: verif/flash_cmd_engine_test.sv
// Self-checking bench for the flash command engine
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module flash_cmd_engine_test;
    localparam int PP = 300;
    localparam int SE = 20;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n_pin, sclk_pin, write_enable_set = 1'b0, otp_lock_bit = 1'b0;
    logic [3:0]  io_pin;
    logic [2:0]  per_region_lock_bits = 3'h0;
    logic        quad_io_allow = 1'b0;
    logic [4:0]  region_protect_field = 5'h00;
    logic        write_latch_flag, op_in_progress_flag, device_busy, mem_wr_en, mem_wr_secure;
    logic [23:0] mem_wr_addr;
    logic [7:0]  mem_wr_data;
    logic        sec_erase_pulse, soft_reset_pulse, busy_seen, ws;
    logic [23:0] wa[$];
    logic [7:0]  wd[$];
    logic [7:0]  dbuf[4] = '{8'ha1, 8'hb2, 8'hc3, 8'h9c};
    int          n_erase, n_rst, n_busy, cnt, miscompares = 0, n_checks = 0;

    always #5 clock = ~clock;
    spi_host_model i_spi_host_model (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_pin(io_pin));
    flash_cmd_engine #(.PP_CYCLES(PP), .SE_CYCLES(SE)) i_flash_cmd_engine (
        .clock(clock), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_pin(io_pin),
        .write_enable_set(write_enable_set), .otp_lock_bit(otp_lock_bit),
        .per_region_lock_bits(per_region_lock_bits), .quad_io_allow(quad_io_allow),
        .region_protect_field(region_protect_field), .write_latch_flag(write_latch_flag),
        .op_in_progress_flag(op_in_progress_flag), .device_busy(device_busy),
        .mem_wr_en(mem_wr_en), .mem_wr_secure(mem_wr_secure), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .sec_erase_pulse(sec_erase_pulse),
        .soft_reset_pulse(soft_reset_pulse));

    // Records what the engine does while a command runs
    always @(negedge clock) begin
        if (device_busy === 1'b1) busy_seen = 1'b1;
        if (op_in_progress_flag === 1'b1) n_busy++;
        if (sec_erase_pulse === 1'b1) n_erase++;
        if (soft_reset_pulse === 1'b1) n_rst++;
        if (mem_wr_en === 1'b1) begin
            wa.push_back(mem_wr_addr);
            wd.push_back(mem_wr_data);
            ws = mem_wr_secure;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One frame: optional write enable, opcode, address bytes, data bytes, stray bits
    task automatic cmd(input logic we, input logic [7:0] op, input int na, input logic [23:0] a,
                       input int nd, input int tail, input logic q, input logic nw);
        int i;
        if (we) begin
            @(negedge clock) write_enable_set = 1'b1;
            @(negedge clock) write_enable_set = 1'b0;
            `CHK("latch set", 1'b1, write_latch_flag)
        end
        busy_seen = 1'b0;
        n_erase = 0;
        n_rst = 0;
        n_busy = 0;
        wa.delete();
        wd.delete();
        i_spi_host_model.open_frame();
        i_spi_host_model.put_bits(op, 8, 1'b0);
        for (i = 0; i < na; i++) i_spi_host_model.put_bits(a[23 - 8 * i -: 8], 8, 1'b0);
        for (i = 0; i < nd; i++) i_spi_host_model.put_bits(dbuf[i], 8, q);
        if (tail > 0) i_spi_host_model.put_bits(8'hff, tail, 1'b0);
        i_spi_host_model.close_frame();
        cnt = 0;
        // Host waits for idle before the next command unless nw is set
        while (!nw && device_busy !== 1'b0 && cnt < 4000) begin
            @(negedge clock);
            cnt++;
        end
        if (cnt >= 4000) begin
            `CHK("idle wait", 1'b0, device_busy)
            test_done();
        end
        repeat (3) @(negedge clock);
    endtask

    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (5) @(negedge clock);
        cmd(0, 8'h02, 3, 24'h0012fe, 1, 0, 0, 0);
        `CHK("prog no latch", 1'b0, busy_seen)
        cmd(1, 8'h02, 3, 24'h0012fe, 3, 0, 0, 0);
        `CHK("prog time", PP, n_busy)
        `CHK("latch clear", 1'b0, write_latch_flag)
        `CHK("write count", 3, wa.size())
        `CHK("wrap addr", 24'h001200, wa[0])
        `CHK("wrap data", 8'hc3, wd[0])
        `CHK("last addr", 24'h0012ff, wa[2])
        `CHK("main space", 1'b0, ws)
        $display("test page program done");
        cmd(1, 8'h02, 3, 24'h000100, 1, 3, 0, 0);
        `CHK("mid byte", 1'b0, busy_seen)
        cmd(1, 8'h44, 0, 24'h0, 0, 0, 0, 0);
        `CHK("erase", 1, n_erase)
        `CHK("erase time", SE, n_busy)
        cmd(1, 8'h44, 1, 24'h0, 0, 0, 0, 0);
        `CHK("erase extra", 0, n_erase)
        otp_lock_bit = 1'b1;
        cmd(1, 8'h44, 0, 24'h0, 0, 0, 0, 0);
        `CHK("erase locked", 0, n_erase)
        $display("test security erase done");
        cmd(1, 8'h42, 3, 24'h002005, 1, 0, 0, 0);
        `CHK("sec addr", 24'h002005, wa[0])
        `CHK("sec space", 1'b1, ws)
        per_region_lock_bits = 3'h2;
        cmd(1, 8'h42, 3, 24'h002005, 1, 0, 0, 0);
        `CHK("sec locked", 1'b0, busy_seen)
        $display("test security program done");
        cmd(1, 8'h32, 3, 24'h004010, 4, 0, 1, 0);
        `CHK("quad off", 1'b0, busy_seen)
        quad_io_allow = 1'b1;
        cmd(1, 8'h32, 3, 24'h004010, 4, 0, 1, 0);
        `CHK("quad data", 8'h9c, wd[3])
        region_protect_field = 5'h18;
        cmd(1, 8'h02, 3, 24'h000010, 1, 0, 0, 0);
        `CHK("protected", 1'b0, busy_seen)
        region_protect_field = 5'h00;
        $display("test quad and protect done");
        cmd(1, 8'h02, 3, 24'h000020, 1, 0, 0, 1);
        cmd(1, 8'h44, 0, 24'h0, 0, 0, 0, 0);
        `CHK("erase while busy", 0, n_erase)
        cmd(0, 8'h66, 0, 24'h0, 0, 0, 0, 0);
        cmd(0, 8'h02, 0, 24'h0, 0, 0, 0, 0);
        cmd(0, 8'h99, 0, 24'h0, 0, 0, 0, 0);
        `CHK("reset cancel", 0, n_rst)
        cmd(1, 8'h66, 0, 24'h0, 0, 0, 0, 0);
        cmd(0, 8'h99, 0, 24'h0, 0, 0, 0, 1);
        `CHK("reset", 1, n_rst)
        `CHK("reset latch", 1'b0, write_latch_flag)
        otp_lock_bit = 1'b0;
        cmd(1, 8'h44, 0, 24'h0, 0, 0, 0, 0);
        `CHK("reset interval", 0, n_erase)
        $display("test reset done");
        test_done();
    end
endmodule

// File: verif/spi_host_model.sv
// Host controller model driving the serial flash pins
`timescale 1ns/1ns
module spi_host_model (
    output logic       cs_n_pin,
    output logic       sclk_pin,
    output logic [3:0] io_pin
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        io_pin   = 4'h5;
    end
    task automatic open_frame();
        cs_n_pin = 1'b0;
        #63;
    endtask
    // Data changes while the clock is low, ahead of the rising sample edge
    // Half periods of 61 and 64 ns keep every pin change off the system clock edges
    task automatic put_bits(input logic [7:0] b, input int n, input logic quad);
        int i;
        for (i = 0; i < (quad ? 2 : n); i++) begin
            io_pin = quad ? b[7 - 4 * i -: 4] : {~io_pin[3:1], b[7 - i]};
            #61 sclk_pin = 1'b1;
            #64 sclk_pin = 1'b0;
        end
    endtask
    // Frame ends only where the caller stops sending bits
    task automatic close_frame();
        #60 cs_n_pin = 1'b1;
        io_pin = ~io_pin;
        #200;
    endtask
endmodule
